// ---- pnpld_checker.sv ----
// Port-level assertions for the logical device configuration bank
`timescale 1ns/1ps
`include "pnpld_map.svh"
module pnpld_checker (
    // Clock and reset
    input wire logic                           clk,
    input wire logic                           srst,
    // Register bus
    input wire pnpld_pkg::pnpld_axi_req_s      axi_req,
    input wire pnpld_pkg::pnpld_axi_rsp_s      axi_rsp,
    // Range check pins
    input wire logic                           io_rd_n,
    input wire logic [15:0]                    io_addr,
    input wire logic [7:0]                     io_data_out,
    input wire logic                           io_data_oe,
    // Requests and request pins
    input wire logic [`PNPLD_NUM_DEV-1:0]      dev_irq_req,
    input wire logic [`PNPLD_NUM_DEV-1:0][1:0] dev_dma_req,
    input wire logic [15:0]                    interrupt_line_out,
    input wire logic [15:0]                    interrupt_line_oe,
    input wire logic [7:0]                     dma_drq
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Reset must not be masked here, so its own disable is off
    reset_idle_a: assert property (disable iff (1'b0) srst |=> axi_rsp.awready && axi_rsp.arready
        && !axi_rsp.bvalid && !axi_rsp.rvalid && !io_data_oe && dma_drq == 8'h00) else $error("outputs not idle");
    upper_zero_a: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    rc_byte_a: assert property (io_data_oe |-> io_data_out == 8'h55 || io_data_out == 8'hAA)
        else $error("range check byte wrong");
    rc_rise_a: assert property ($rose(io_data_oe) |-> !$past(io_rd_n, 3))
        else $error("range check drive without read");
    rc_release_a: assert property (io_rd_n [*3] |=> !io_data_oe)
        else $error("range check drive after read");
    line_zero_a: assert property (!interrupt_line_oe[0])
        else $error("interrupt line zero driven");
    cascade_none_a: assert property (!dma_drq[4])
        else $error("cascade channel requested");
    dma_cause_a: assert property (dma_drq != 8'h00 |-> $past(dev_dma_req) != '0)
        else $error("DMA request without cause");
    dma_quiet_a: assert property (dev_dma_req == '0 |=> dma_drq == 8'h00)
        else $error("DMA request not withdrawn");
endmodule

bind pnpld_top pnpld_checker chk_i (.clk(clk), .srst(srst), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .io_rd_n(io_rd_n), .io_addr(io_addr), .io_data_out(io_data_out), .io_data_oe(io_data_oe),
    .dev_irq_req(dev_irq_req), .dev_dma_req(dev_dma_req), .interrupt_line_out(interrupt_line_out),
    .interrupt_line_oe(interrupt_line_oe), .dma_drq(dma_drq));

// ---- pnpld_dev_regs.sv ----
// One logical device: its configuration registers, interrupt driver and DMA gating
`timescale 1ns/1ps
`include "pnpld_map.svh"

module pnpld_dev_regs #(
    parameter bit          TYPE_RO = 1'b0,
    parameter logic [15:0] IO_SPAN = `PNPLD_IO_SPAN
) (
    // Clock and reset, soft reset included
    input  wire logic        clk,
    input  wire logic        srst,
    // Register access
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_idx,
    input  wire logic [7:0]  wr_data,
    input  wire logic [7:0]  rd_idx,
    output logic      [7:0]  rd_data,
    // Range check probe
    input  wire logic        io_rd,
    input  wire logic [15:0] io_addr,
    output logic             rc_hit,
    output logic      [7:0]  rc_data,
    // Requests from the device core and their gated forms
    input  wire logic        irq_req,
    input  wire logic [1:0]  dma_req,
    output logic      [3:0]  irq_line,
    output logic             irq_oe,
    output logic             irq_val,
    output logic      [1:0]  drq,
    output logic      [2:0]  dma0_ch,
    output logic      [2:0]  dma1_ch
);
    localparam logic [7:0] PULLUP_CYC = 8'(`PNPLD_PULLUP_CYC);
    localparam logic [7:0] EDGE_CYC   = 8'(`PNPLD_EDGE_CYC);

    pnpld_pkg::pnpld_dev_s s_q;
    pnpld_pkg::pnpld_dev_s s_d;
    logic                  en;
    logic                  want;
    logic                  pol_high;
    logic [15:0]           d0;
    logic [15:0]           d1;

    always_comb
    begin
        s_d = s_q;
        if (wr_en)
        begin
            case (wr_idx)
                `PNPLD_IDX_ACT:  s_d.active = wr_data[`PNPLD_BIT_ACT];
                `PNPLD_IDX_RCHK:
                begin
                    s_d.rc_en  = wr_data[`PNPLD_BIT_RC_EN];
                    s_d.rc_pat = wr_data[`PNPLD_BIT_RC_PAT];
                end
                `PNPLD_IDX_B0H:  s_d.base0[15:8] = wr_data;
                `PNPLD_IDX_B0L:  s_d.base0[7:0]  = wr_data;
                `PNPLD_IDX_B1H:  s_d.base1[15:8] = wr_data;
                `PNPLD_IDX_B1L:  s_d.base1[7:0]  = wr_data;
                `PNPLD_IDX_IRQS: s_d.irq_sel = wr_data[3:0];
                `PNPLD_IDX_IRQT: s_d.irq_type = TYPE_RO ? s_q.irq_type : wr_data[1:0];
                `PNPLD_IDX_DMA0: s_d.dma0 = wr_data[2:0];
                `PNPLD_IDX_DMA1: s_d.dma1 = wr_data[2:0];
                default:         s_d.dma1 = s_q.dma1;
            endcase
        end

        // no line or inactive means silent
        en       = s_q.active && (s_q.irq_sel != `PNPLD_IRQ_NONE);
        pol_high = s_q.irq_type[`PNPLD_BIT_TYPE_POL];
        // level follows request, edge gives a pulse
        want     = s_q.irq_type[`PNPLD_BIT_TYPE_LVL] ? irq_req : (s_q.pulse_cnt != 8'h00);
        s_d.req_prev = irq_req;
        if (irq_req && !s_q.req_prev)
            s_d.pulse_cnt = EDGE_CYC;
        else if (s_q.pulse_cnt != 8'h00)
            s_d.pulse_cnt = s_q.pulse_cnt - 8'h01;

        // low polarity releases through a short strong pull-up
        unique case (s_q.irq_st)
            pnpld_pkg::PNPLD_IRQ_IDLE:
                if (en && want)
                    s_d.irq_st = pnpld_pkg::PNPLD_IRQ_ON;
            pnpld_pkg::PNPLD_IRQ_ON:
                if (!(en && want))
                begin
                    s_d.irq_st   = pol_high ? pnpld_pkg::PNPLD_IRQ_IDLE : pnpld_pkg::PNPLD_IRQ_PULL;
                    s_d.pull_cnt = PULLUP_CYC - 8'h01;
                end
            pnpld_pkg::PNPLD_IRQ_PULL:
                if (en && want)
                    s_d.irq_st = pnpld_pkg::PNPLD_IRQ_ON;
                else if (s_q.pull_cnt == 8'h00)
                    s_d.irq_st = pnpld_pkg::PNPLD_IRQ_IDLE;
                else
                    s_d.pull_cnt = s_q.pull_cnt - 8'h01;
            default:
                s_d.irq_st = pnpld_pkg::PNPLD_IRQ_IDLE;
        endcase

        // push-pull when high, open-drain when low
        irq_line = s_q.irq_sel;
        // pending pull-up dropped once line deselected, never lands on line 0
        irq_oe   = pol_high ? en : ((s_q.irq_st != pnpld_pkg::PNPLD_IRQ_IDLE)
                                    && (s_q.irq_sel != `PNPLD_IRQ_NONE));
        irq_val  = pol_high ? (s_q.irq_st == pnpld_pkg::PNPLD_IRQ_ON)
                            : (s_q.irq_st == pnpld_pkg::PNPLD_IRQ_PULL);

        // cascade channel or inactive issues nothing
        drq[0]  = s_q.active && (s_q.dma0 != `PNPLD_DMA_NONE) && dma_req[0];
        drq[1]  = s_q.active && (s_q.dma1 != `PNPLD_DMA_NONE) && dma_req[1];
        dma0_ch = s_q.dma0;
        dma1_ch = s_q.dma1;

        // answer in range only while inactive and enabled
        d0      = io_addr - s_q.base0;
        d1      = io_addr - s_q.base1;
        rc_hit  = io_rd && s_q.rc_en && !s_q.active && ((d0 < IO_SPAN) || (d1 < IO_SPAN));
        rc_data = s_q.rc_pat ? `PNPLD_RC_DATA_ONE : `PNPLD_RC_DATA_ZERO;

        case (rd_idx)
            `PNPLD_IDX_ACT:  rd_data = {7'h00, s_q.active};
            `PNPLD_IDX_RCHK: rd_data = {6'h00, s_q.rc_en, s_q.rc_pat};
            `PNPLD_IDX_B0H:  rd_data = s_q.base0[15:8];
            `PNPLD_IDX_B0L:  rd_data = s_q.base0[7:0];
            `PNPLD_IDX_B1H:  rd_data = s_q.base1[15:8];
            `PNPLD_IDX_B1L:  rd_data = s_q.base1[7:0];
            `PNPLD_IDX_IRQS: rd_data = {4'h0, s_q.irq_sel};
            `PNPLD_IDX_IRQT: rd_data = {6'h00, s_q.irq_type};
            `PNPLD_IDX_DMA0: rd_data = {5'h00, s_q.dma0};
            `PNPLD_IDX_DMA1: rd_data = {5'h00, s_q.dma1};
            default:         rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        // hard or soft reset restores defaults
        if (srst)
        begin
            s_q          <= '0;
            s_q.base0    <= `PNPLD_RST_BASE;
            s_q.base1    <= `PNPLD_RST_BASE;
            s_q.irq_sel  <= `PNPLD_RST_IRQ_SEL;
            s_q.irq_type <= `PNPLD_RST_IRQ_TYPE;
            s_q.dma0     <= `PNPLD_RST_DMA;
            s_q.dma1     <= `PNPLD_RST_DMA;
            s_q.irq_st   <= pnpld_pkg::PNPLD_IRQ_IDLE;
        end
        else
            s_q <= s_d;
    end
endmodule

// ---- pnpld_isa_host.sv ----
// ISA host model issuing range-check I/O reads
`timescale 1ns/1ps
module pnpld_isa_host (
    // Clock
    input wire logic  clk,
    // Answer from the card
    input wire logic  io_data_oe,
    input wire logic  [7:0] io_data_out,
    // Strobe and address
    output logic      io_rd_n,
    output logic      [15:0] io_addr
);
    initial
    begin
        io_rd_n = 1'b1;
        io_addr = 16'hFFFF;
    end
    task automatic io_read(input logic [15:0] a, output logic oe, output logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_rd_n <= 1'b0;
        // Long enough for the two-flop sync and output flop
        repeat (6) @(posedge clk);
        oe = io_data_oe;
        d = io_data_out;
        io_rd_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Released address shows a changed value, not the old one
        io_addr <= ~a;
    endtask
endmodule

// ---- pnpld_map.svh ----
// Register indices, field positions, reset values and timing counts of the logical device block
`ifndef PNPLD_MAP_SVH
`define PNPLD_MAP_SVH

`define PNPLD_NUM_DEV      2
`define PNPLD_AW           12

`define PNPLD_IDX_CTRL     8'h02
`define PNPLD_IDX_LDN      8'h07
`define PNPLD_IDX_ACT      8'h30
`define PNPLD_IDX_RCHK     8'h31
`define PNPLD_IDX_B0H      8'h60
`define PNPLD_IDX_B0L      8'h61
`define PNPLD_IDX_B1H      8'h62
`define PNPLD_IDX_B1L      8'h63
`define PNPLD_IDX_IRQS     8'h70
`define PNPLD_IDX_IRQT     8'h71
`define PNPLD_IDX_DMA0     8'h74
`define PNPLD_IDX_DMA1     8'h75

`define PNPLD_BIT_ACT      0
`define PNPLD_BIT_RC_PAT   0
`define PNPLD_BIT_RC_EN    1
`define PNPLD_BIT_TYPE_LVL 0
`define PNPLD_BIT_TYPE_POL 1
`define PNPLD_BIT_SOFT_RST 0

`define PNPLD_RST_BASE     16'h0000
`define PNPLD_RST_IRQ_SEL  4'h0
`define PNPLD_RST_IRQ_TYPE 2'h2
`define PNPLD_RST_DMA      3'h4
`define PNPLD_RST_LDN      8'h00

`define PNPLD_IRQ_NONE     4'h0
`define PNPLD_DMA_NONE     3'h4
`define PNPLD_RC_DATA_ONE  8'h55
`define PNPLD_RC_DATA_ZERO 8'hAA
`define PNPLD_IO_SPAN      16'h0008

`define PNPLD_RESP_OKAY    2'h0
`define PNPLD_RESP_DECERR  2'h3

`define PNPLD_CLK_NS       4
`define PNPLD_PULLUP_NS    20
`define PNPLD_EDGE_NS      100
`define PNPLD_PULLUP_CYC   ((`PNPLD_PULLUP_NS + `PNPLD_CLK_NS - 1) / `PNPLD_CLK_NS)
`define PNPLD_EDGE_CYC     ((`PNPLD_EDGE_NS + `PNPLD_CLK_NS - 1) / `PNPLD_CLK_NS)

`endif

// ---- pnpld_pkg.sv ----
// Types shared by the logical device configuration block
`include "pnpld_map.svh"

package pnpld_pkg;

    typedef struct packed {
        logic                   awvalid;
        logic [`PNPLD_AW-1:0]   awaddr;
        logic                   wvalid;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bready;
        logic                   arvalid;
        logic [`PNPLD_AW-1:0]   araddr;
        logic                   rready;
    } pnpld_axi_req_s;

    typedef struct packed {
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } pnpld_axi_rsp_s;

    typedef enum logic [1:0] {
        PNPLD_IRQ_IDLE = 2'b00,
        PNPLD_IRQ_ON   = 2'b01,
        PNPLD_IRQ_PULL = 2'b10
    } pnpld_irq_e;

    typedef struct packed {
        logic                   active;
        logic                   rc_en;
        logic                   rc_pat;
        logic [15:0]            base0;
        logic [15:0]            base1;
        logic [3:0]             irq_sel;
        logic [1:0]             irq_type;
        logic [2:0]             dma0;
        logic [2:0]             dma1;
        logic                   req_prev;
        logic [7:0]             pulse_cnt;
        logic [7:0]             pull_cnt;
        pnpld_irq_e             irq_st;
    } pnpld_dev_s;

    typedef struct packed {
        logic                   rd_n_m;
        logic                   rd_n_s;
        logic [15:0]            addr_m;
        logic [15:0]            addr_s;
        logic                   aw_have;
        logic                   aw_ok;
        logic [7:0]             aw_idx;
        logic                   w_have;
        logic                   w_en;
        logic [7:0]             w_data;
        pnpld_axi_rsp_s         rsp;
        logic [7:0]             ldn;
        logic                   soft_rst;
        logic [7:0]             io_data;
        logic                   io_oe;
        logic [15:0]            irq_out;
        logic [15:0]            irq_oe;
        logic [7:0]             drq;
    } pnpld_top_s;

endpackage

// ---- pnpld_top.sv ----
// Logical device configuration bank with AXI4-Lite access and ISA-side outputs
//
// Operation
// - Each device has an activation bit 0; upper bits read zero.
// - Range-check bit 1 enables the check, only while inactive; bits 7-2 zero.
// - Enabled check answers in-range I/O reads with 55h or AAh by bit 0.
// - Descriptor 0 base: high byte at index 60h, low at 61h.
// - Descriptor 1 base: high byte at index 62h, low at 63h.
// - Interrupt select bits 3-0 pick interrupt line 1 to 15.
// - Interrupt select zero means no line; nothing is driven.
// - Interrupt type bit 0: zero edge, one level.
// - Type bit 1: high push-pull, low open-drain with brief strong pull-up.
// - Interrupt type register may be read-only for single-style devices.
// - First DMA select bits 2-0 choose channel 0 to 7.
// - Second DMA select bits 2-0 choose channel 0 to 7.
// - DMA select 4 means no channel and no requests.
// - Logical device number picks the register set reached and activated.
// - Soft reset restores all devices to defaults, keeping card select number.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pnpld_map.svh"

module pnpld_top #(
    parameter logic [15:0]               IO_SPAN     = `PNPLD_IO_SPAN,
    parameter logic [`PNPLD_NUM_DEV-1:0] IRQ_TYPE_RO = '0
) (
    // Clock and reset
    input  wire logic                             clk,
    input  wire logic                             srst,
    // AXI4-Lite slave
    input  wire pnpld_pkg::pnpld_axi_req_s        axi_req,
    output pnpld_pkg::pnpld_axi_rsp_s             axi_rsp,
    // ISA I/O read probe pins
    input  wire logic                             io_rd_n,
    input  wire logic [15:0]                      io_addr,
    output logic      [7:0]                       io_data_out,
    output logic                                  io_data_oe,
    // Requests from the device cores
    input  wire logic [`PNPLD_NUM_DEV-1:0]        dev_irq_req,
    input  wire logic [`PNPLD_NUM_DEV-1:0][1:0]   dev_dma_req,
    // ISA interrupt and DMA request pins
    output logic      [15:0]                      interrupt_line_out,
    output logic      [15:0]                      interrupt_line_oe,
    output logic      [7:0]                       dma_drq
);
    localparam int ND = `PNPLD_NUM_DEV;

    pnpld_pkg::pnpld_top_s    s_q;
    pnpld_pkg::pnpld_top_s    s_d;

    logic                     wr_go;
    logic [7:0]               ar_idx;
    logic                     ar_ok;
    logic [7:0]               rd_byte;
    logic                     ldn_ok;
    logic                     idx_mapped;
    logic [ND-1:0]            dev_wr;
    logic [ND-1:0][7:0]       dev_rd;
    logic [ND-1:0]            dev_hit;
    logic [ND-1:0][7:0]       dev_rc;
    logic [ND-1:0][3:0]       dev_line;
    logic [ND-1:0]            dev_oe;
    logic [ND-1:0]            dev_val;
    logic [ND-1:0][1:0]       dev_drq;
    logic [ND-1:0][2:0]       dev_ch0;
    logic [ND-1:0][2:0]       dev_ch1;

    // Index lives in bits 9-2; anything else set is unmapped
    function automatic logic idx_known(input logic [7:0] idx);
        case (idx)
            `PNPLD_IDX_CTRL, `PNPLD_IDX_LDN,
            `PNPLD_IDX_ACT,  `PNPLD_IDX_RCHK,
            `PNPLD_IDX_B0H,  `PNPLD_IDX_B0L,
            `PNPLD_IDX_B1H,  `PNPLD_IDX_B1L,
            `PNPLD_IDX_IRQS, `PNPLD_IDX_IRQT,
            `PNPLD_IDX_DMA0, `PNPLD_IDX_DMA1: idx_known = 1'b1;
            default:                          idx_known = 1'b0;
        endcase
    endfunction

    function automatic logic addr_ok(input logic [`PNPLD_AW-1:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a[`PNPLD_AW-1:10] == '0) && idx_known(a[9:2]);
    endfunction

    genvar g;
    generate
        for (g = 0; g < ND; g++)
        begin : g_dev
            pnpld_dev_regs #(
                .TYPE_RO (IRQ_TYPE_RO[g]),
                .IO_SPAN (IO_SPAN)
            ) u_dev (
                .clk      (clk),
                .srst     (srst | s_q.soft_rst),
                .wr_en    (dev_wr[g]),
                .wr_idx   (s_q.aw_idx),
                .wr_data  (s_q.w_data),
                .rd_idx   (ar_idx),
                .rd_data  (dev_rd[g]),
                .io_rd    (!s_q.rd_n_s),
                .io_addr  (s_q.addr_s),
                .rc_hit   (dev_hit[g]),
                .rc_data  (dev_rc[g]),
                .irq_req  (dev_irq_req[g]),
                .dma_req  (dev_dma_req[g]),
                .irq_line (dev_line[g]),
                .irq_oe   (dev_oe[g]),
                .irq_val  (dev_val[g]),
                .drq      (dev_drq[g]),
                .dma0_ch  (dev_ch0[g]),
                .dma1_ch  (dev_ch1[g])
            );
            // only the selected device takes writes
            assign dev_wr[g] = wr_go && s_q.w_en && s_q.aw_ok && (s_q.ldn == 8'(g));
        end
    endgenerate

    assign wr_go      = s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid;
    assign ar_idx     = axi_req.araddr[9:2];
    assign ar_ok      = addr_ok(axi_req.araddr);
    assign ldn_ok     = s_q.ldn < 8'(ND);
    assign idx_mapped = ar_ok;

    // Read byte for the address on the read channel
    always_comb
    begin
        rd_byte = 8'h00;
        if (ar_idx == `PNPLD_IDX_LDN)
            rd_byte = s_q.ldn;
        else if (ar_idx != `PNPLD_IDX_CTRL && ldn_ok)
            rd_byte = dev_rd[s_q.ldn[$clog2(ND)-1:0]];
    end

    always_comb
    begin
        s_d          = s_q;
        s_d.soft_rst = 1'b0;

        // Pins cross from the ISA side through two stages
        s_d.rd_n_m = io_rd_n;
        s_d.rd_n_s = s_q.rd_n_m;
        s_d.addr_m = io_addr;
        s_d.addr_s = s_q.addr_m;

        // Write address and data are taken independently
        if (axi_req.awvalid && s_q.rsp.awready)
        begin
            s_d.aw_have = 1'b1;
            s_d.aw_ok   = addr_ok(axi_req.awaddr);
            s_d.aw_idx  = axi_req.awaddr[9:2];
        end
        if (axi_req.wvalid && s_q.rsp.wready)
        begin
            s_d.w_have = 1'b1;
            s_d.w_en   = axi_req.wstrb[0];
            s_d.w_data = axi_req.wdata[7:0];
        end
        if (wr_go)
        begin
            s_d.aw_have    = 1'b0;
            s_d.w_have     = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp  = s_q.aw_ok ? `PNPLD_RESP_OKAY : `PNPLD_RESP_DECERR;
            if (s_q.aw_ok && s_q.w_en)
            begin
                if (s_q.aw_idx == `PNPLD_IDX_LDN)
                    s_d.ldn = s_q.w_data;
                if (s_q.aw_idx == `PNPLD_IDX_CTRL)
                    s_d.soft_rst = s_q.w_data[`PNPLD_BIT_SOFT_RST];
            end
        end
        if (s_q.rsp.bvalid && axi_req.bready)
            s_d.rsp.bvalid = 1'b0;
        s_d.rsp.awready = !s_d.aw_have && !s_d.rsp.bvalid;
        s_d.rsp.wready  = !s_d.w_have && !s_d.rsp.bvalid;

        // Read answers on the same edge that takes the address
        if (axi_req.arvalid && s_q.rsp.arready)
        begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata  = {24'h000000, idx_mapped ? rd_byte : 8'h00};
            s_d.rsp.rresp  = idx_mapped ? `PNPLD_RESP_OKAY : `PNPLD_RESP_DECERR;
        end
        else if (s_q.rsp.rvalid && axi_req.rready)
            s_d.rsp.rvalid = 1'b0;
        s_d.rsp.arready = !s_d.rsp.rvalid;

        // range check data onto the bus
        s_d.io_oe   = 1'b0;
        s_d.io_data = 8'h00;
        for (int i = 0; i < ND; i++)
        begin
            if (dev_hit[i])
            begin
                s_d.io_oe   = 1'b1;
                s_d.io_data = dev_rc[i];
            end
        end

        // route each device to its line; last device wins a clash
        s_d.irq_out = 16'h0000;
        s_d.irq_oe  = 16'h0000;
        s_d.drq     = 8'h00;
        for (int i = 0; i < ND; i++)
        begin
            if (dev_oe[i])
            begin
                s_d.irq_oe[dev_line[i]]  = 1'b1;
                s_d.irq_out[dev_line[i]] = dev_val[i];
            end
            if (dev_drq[i][0])
                s_d.drq[dev_ch0[i]] = 1'b1;
            if (dev_drq[i][1])
                s_d.drq[dev_ch1[i]] = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_q             <= '0;
            s_q.rd_n_m      <= 1'b1;
            s_q.rd_n_s      <= 1'b1;
            s_q.ldn         <= `PNPLD_RST_LDN;
            s_q.rsp.awready <= 1'b1;
            s_q.rsp.wready  <= 1'b1;
            s_q.rsp.arready <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign axi_rsp            = s_q.rsp;
    assign io_data_out        = s_q.io_data;
    assign io_data_oe         = s_q.io_oe;
    assign interrupt_line_out = s_q.irq_out;
    assign interrupt_line_oe  = s_q.irq_oe;
    assign dma_drq            = s_q.drq;
endmodule

// ---- pnpld_top_tb_top.sv ----
// Self-checking bench for the logical device configuration bank
`timescale 1ns/1ps
`include "pnpld_map.svh"
module pnpld_top_tb_top;
    logic                           clk, srst, io_rd_n, io_oe;
    pnpld_pkg::pnpld_axi_req_s      req;
    pnpld_pkg::pnpld_axi_rsp_s      rsp;
    logic [15:0]                    io_addr, irq_o, irq_oe;
    logic [7:0]                     io_do, drq;
    logic [`PNPLD_NUM_DEV-1:0]      irq_rq;
    logic [`PNPLD_NUM_DEV-1:0][1:0] dma_rq;
    logic [33:0]                    exq[$];
    logic [31:0]                    xs_st = 32'h8959;
    logic [31:0]                    r;
    int                             fail_count = 0, compares = 0, cyc = 0;
    logic [7:0] ix [10] = '{8'h30, 8'h31, 8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h71, 8'h74, 8'h75};
    logic [7:0] mk [10] = '{8'h01, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h03, 8'h07, 8'h07};
    logic [7:0] dv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h04, 8'h04};
    pnpld_top uut (.clk(clk), .srst(srst), .axi_req(req), .axi_rsp(rsp), .io_rd_n(io_rd_n),
        .io_addr(io_addr), .io_data_out(io_do), .io_data_oe(io_oe), .dev_irq_req(irq_rq),
        .dev_dma_req(dma_rq), .interrupt_line_out(irq_o), .interrupt_line_oe(irq_oe), .dma_drq(drq));
    pnpld_isa_host host (.clk(clk), .io_data_oe(io_oe), .io_data_out(io_do), .io_rd_n(io_rd_n),
        .io_addr(io_addr));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        xs_st ^= xs_st << 13;
        xs_st ^= xs_st >> 17;
        xs_st ^= xs_st << 5;
        return xs_st;
    endfunction
    task automatic end_sim();
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        compares++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] rs);
        exq.push_back({rs, 32'h00000000});
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr <= {2'b00, i, 2'b00};
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] v, input logic [1:0] rs);
        exq.push_back({rs, 24'h000000, v});
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr <= {2'b00, i, 2'b00};
        req.rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
    endtask
    task automatic rc(input logic [15:0] a, input logic oe, input logic [7:0] d);
        logic       o;
        logic [7:0] v;
        host.io_read(a, o, v);
        chk(34'({o, v & {8{o}}}), 34'({oe, d}));
    endtask
    // Bus answers against the oldest noted result
    always @(posedge clk)
        if (srst === 1'b0 && ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready)))
            chk(rsp.rvalid ? {rsp.rresp, rsp.rdata} : {rsp.bresp, 32'h00000000}, exq.pop_front());
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            end_sim();
        end
    end
    initial
    begin
        srst = 1'b1;
        req = '0;
        irq_rq = '0;
        dma_rq = '0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 10; i++) rd(ix[i], dv[i], 2'h0);
        for (int i = 0; i < 10; i++)
        begin
            r = xs();
            wr(ix[i], r, 2'h0);
            rd(ix[i], r[7:0] & mk[i], 2'h0);
        end
        wr(8'h07, 32'h1, 2'h0);
        rd(8'h30, 8'h00, 2'h0);
        wr(8'h60, 32'h5A, 2'h0);
        wr(8'h02, 32'h1, 2'h0);
        rd(8'h07, 8'h01, 2'h0);
        for (int i = 0; i < 10; i++) rd(ix[i], dv[i], 2'h0);
        wr(8'h07, 32'h2, 2'h0);
        rd(8'h60, 8'h00, 2'h0);
        wr(8'h3F, 32'h1, 2'h3);
        rd(8'h3F, 8'h00, 2'h3);
        wr(8'h07, 32'h0, 2'h0);
        wr(8'h30, 32'h0, 2'h0);
        wr(8'h60, 32'h03, 2'h0);
        wr(8'h61, 32'h00, 2'h0);
        wr(8'h62, 32'h04, 2'h0);
        wr(8'h63, 32'h10, 2'h0);
        wr(8'h31, 32'h03, 2'h0);
        rc(16'h0303, 1'b1, 8'h55);
        rc(16'h0308, 1'b0, 8'h00);
        wr(8'h31, 32'h02, 2'h0);
        rc(16'h0307, 1'b1, 8'hAA);
        rc(16'h0410, 1'b1, 8'hAA);
        wr(8'h31, 32'h00, 2'h0);
        rc(16'h0303, 1'b0, 8'h00);
        wr(8'h74, 32'h2, 2'h0);
        wr(8'h75, 32'h7, 2'h0);
        wr(8'h70, 32'h5, 2'h0);
        wr(8'h71, 32'h3, 2'h0);
        wr(8'h30, 32'h1, 2'h0);
        irq_rq <= '1;
        dma_rq <= '1;
        repeat (4) @(posedge clk);
        chk(34'(drq), 34'h84);
        chk(34'({irq_oe[5], irq_o[5]}), 34'h3);
        wr(8'h74, 32'h4, 2'h0);
        repeat (2) @(posedge clk);
        chk(34'(drq), 34'h80);
        wr(8'h71, 32'h1, 2'h0);
        repeat (3) @(posedge clk);
        chk(34'({irq_oe[5], irq_o[5]}), 34'h2);
        irq_rq <= '0;
        repeat (3) @(posedge clk);
        chk(34'({irq_oe[5], irq_o[5]}), 34'h3);
        irq_rq <= '1;
        wr(8'h70, 32'h0, 2'h0);
        repeat (2) @(posedge clk);
        chk(34'(irq_oe), 34'h0);
        wr(8'h30, 32'h0, 2'h0);
        repeat (2) @(posedge clk);
        chk(34'(drq), 34'h0);
        end_sim();
    end
endmodule
